// *** imac_pkg.sv ***
// Package for the internal memory access mode control block
package imac_pkg;
   // Register byte offsets
   localparam logic [7:0] SYSTEM_CONTROL_REG_OFS  = 8'h00;
   localparam logic [7:0] FIRST_MODE_REG_OFS   = 8'h04;
   localparam logic [7:0] SECOND_MODE_REG_OFS   = 8'h08;
   localparam logic [7:0] INTERRUPT_MASK_REG_OFS   = 8'h0c;
   localparam logic [7:0] INTERRUPT_LATCH_REG_OFS   = 8'h10;
   localparam logic [7:0] STICKY_OFS  = 8'h14;
   localparam logic [7:0] STATUS_OFS  = 8'h18;
   // System control fields
   localparam int VT_OVR_BIT   = 2;
   localparam int DW_LO_BIT    = 9;
   localparam int DW_HI_BIT    = 10;
   // First mode register fields
   localparam int SEC_EN_BIT   = 0;
   localparam int BC_LOW_BIT   = 1;
   localparam int BC_HIGH_BIT  = 2;
   // Second mode register fields
   localparam int ILL_IO_BIT   = 0;
   localparam int UNAL_MON_BIT = 21;
   // Interrupt latch / mask / sticky fields
   localparam int ILL_IRQ_BIT  = 0;
   localparam int STK_UNAL_BIT = 0;
   localparam int STK_IO_BIT   = 1;
   // Reset values
   localparam logic [31:0] SYSTEM_CONTROL_REG_RST = 32'h0000_0000;
   localparam logic [31:0] MODE_RST   = 32'h0000_0000;
   localparam logic [31:0] INTERRUPT_MASK_REG_RST  = 32'h0000_0000;
   // Vector table bases
   localparam logic [31:0] VT_INT_BASE = 32'h0008_0000;
   localparam logic [31:0] VT_ROM_BASE = 32'h000a_0000;
   // Block 1 base, normal word address
   localparam logic [31:0] BLK1_BASE   = 32'h000c_0000;
   // Boot DMA length in instructions
   localparam int BOOT_WORDS = 256;
   // Access widths in bits
   localparam logic [6:0] W32 = 7'h20;
   localparam logic [6:0] W48 = 7'h30;
   localparam logic [6:0] W64 = 7'h40;
   // Boot sources
   typedef enum logic [1:0] {
      IMAC_BOOT_PAR  = 2'h0,
      IMAC_BOOT_SPIM = 2'h1,
      IMAC_BOOT_SPIS = 2'h2,
      IMAC_BOOT_NONE = 2'h3
   } imac_boot_e;
   typedef enum logic [1:0] {
      IMAC_IDLE = 2'b00,
      IMAC_LOAD = 2'b01,
      IMAC_DONE = 2'b11
   } imac_bst_e;
endpackage : imac_pkg

// *** imac_ctrl.sv ***
// Internal memory access mode control with AHB-Lite register slave
`timescale 1ns/1ps
module imac_ctrl
   import imac_pkg::*;
#(
   parameter int BOOT_CNT = BOOT_WORDS
)(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // AHB-Lite slave
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic      [31:0] hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   // Boot strap
   input  wire logic [1:0]  boot_mode_i,
   // Core access request
   input  wire logic        acc_valid_i,
   input  wire logic        acc_write_i,
   input  wire logic [31:0] acc_addr_i,
   input  wire logic        acc_normal_i,
   input  wire logic        acc_lw_i,
   input  wire logic        acc_px_i,
   input  wire logic        acc_dreg_i,
   input  wire logic        acc_second_address_generator_i,
   input  wire logic        acc_ptr_match_i,
   input  wire logic        acc_io_reg_i,
   input  wire logic        acc_dma_i,
   input  wire logic [39:0] acc_reg_wdata_i,
   input  wire logic [47:0] acc_mem_rdata_i,
   // Memory-side decisions
   output logic      [6:0]  acc_width_o,
   output logic             acc_dual_o,
   output logic             acc_bcast_o,
   output logic             acc_postmod_first_o,
   output logic      [47:0] acc_mem_wdata_o,
   output logic      [39:0] acc_reg_rdata_o,
   // Vector table, boot DMA and interrupt
   output logic      [31:0] vt_base_o,
   output logic             boot_dma_req_o,
   output logic             boot_done_o,
   input  wire logic        boot_dma_ack_i,
   output logic             illegal_input_condition_irq_o
);
   logic [31:0] system_control_reg_q, first_mode_reg_q, second_mode_reg_q;
   logic [31:0] interrupt_mask_reg_q, interrupt_latch_reg_q, sticky_q;
   logic [31:0] hrdata_q;
   logic        wr_pend_q;
   logic [7:0]  wr_addr_q;
   logic [1:0]  boot_q;
   logic        strap_done_q;
   imac_bst_e   bst_q, bst_d;
   logic [8:0]  bcnt_q;

   // Bus decode
   wire        bus_go   = hsel_i & hready_i & htrans_i[1];
   wire        bus_wr   = bus_go & hwrite_i;
   wire        bus_rd   = bus_go & ~hwrite_i;
   wire [7:0]  baddr    = haddr_i[7:0];
   wire        wr_sys   = wr_pend_q & (wr_addr_q == SYSTEM_CONTROL_REG_OFS);
   wire        wr_m1    = wr_pend_q & (wr_addr_q == FIRST_MODE_REG_OFS);
   wire        wr_m2    = wr_pend_q & (wr_addr_q == SECOND_MODE_REG_OFS);
   wire        wr_msk   = wr_pend_q & (wr_addr_q == INTERRUPT_MASK_REG_OFS);
   wire        wr_lat   = wr_pend_q & (wr_addr_q == INTERRUPT_LATCH_REG_OFS);
   wire        wr_stk   = wr_pend_q & (wr_addr_q == STICKY_OFS);
   wire [31:0] rd_mux   =
      (baddr == SYSTEM_CONTROL_REG_OFS) ? system_control_reg_q  :
      (baddr == FIRST_MODE_REG_OFS)  ? first_mode_reg_q      :
      (baddr == SECOND_MODE_REG_OFS)  ? second_mode_reg_q     :
      (baddr == INTERRUPT_MASK_REG_OFS)  ? interrupt_mask_reg_q  :
      (baddr == INTERRUPT_LATCH_REG_OFS)  ? interrupt_latch_reg_q :
      (baddr == STICKY_OFS) ? sticky_q              :
      (baddr == STATUS_OFS) ? {28'h0000000, boot_q, boot_done_o,
                               boot_dma_req_o} : 32'h0000_0000;

   // Mode bits
   wire vector_table_override   = system_control_reg_q[VT_OVR_BIT];
   wire [1:0] block_data_width_sel =
      system_control_reg_q[DW_HI_BIT:DW_LO_BIT];
   wire secondary_element_enable  = first_mode_reg_q[SEC_EN_BIT];
   wire broadcast_enable_ptr_low  = first_mode_reg_q[BC_LOW_BIT];
   wire broadcast_enable_ptr_high = first_mode_reg_q[BC_HIGH_BIT];
   wire illegal_io_access_enable  = second_mode_reg_q[ILL_IO_BIT];
   wire unaligned_long_monitor_enable = second_mode_reg_q[UNAL_MON_BIT];

   // Access decode
   wire blk_sel   = (acc_addr_i >= BLK1_BASE);
   wire blk_wide  = block_data_width_sel[blk_sel];
   wire forced_lw = acc_normal_i & acc_lw_i;
   wire [6:0] width_d =
      forced_lw  ? W64 :
      acc_px_i   ? W48 :
      blk_wide   ? W48 :
                   W32;
   wire bc_ptr    = acc_second_address_generator_i ? broadcast_enable_ptr_high
                               : broadcast_enable_ptr_low;
   // Broadcast ignores SIMD state entirely
   wire bcast_d   = acc_ptr_match_i & bc_ptr & ~acc_write_i
                  & acc_dreg_i;
   wire dual_d    = (secondary_element_enable & ~forced_lw)
                  | bcast_d;
   wire narrow    = (width_d == W32);
   wire [47:0] wdata_d = narrow ? {16'h0000, acc_reg_wdata_i[39:8]}
                                : {acc_reg_wdata_i, 8'h00};
   wire [39:0] rdata_d = narrow ? {acc_mem_rdata_i[31:0], 8'h00}
                                : acc_mem_rdata_i[47:8];
   wire unal_ev   = acc_valid_i & forced_lw & acc_addr_i[0];
   wire unal_flag = unal_ev & unaligned_long_monitor_enable;
   wire io_ev     = acc_valid_i & acc_io_reg_i & ~acc_dma_i
                  & illegal_io_access_enable;
   wire ill_ev    = io_ev | unal_flag;
   wire ext_boot  = (boot_q != IMAC_BOOT_NONE);
   wire par_boot  = (boot_q == IMAC_BOOT_PAR);
   wire [31:0] vt_d = (vector_table_override | ext_boot)
                    ? VT_INT_BASE : VT_ROM_BASE;

   // Boot DMA sequencer
   always_comb
   begin
      bst_d = bst_q;
      unique case (bst_q)
         IMAC_IDLE: if (strap_done_q) bst_d = par_boot ? IMAC_LOAD
                                                       : IMAC_DONE;
         IMAC_LOAD: if (boot_dma_ack_i &&
                        bcnt_q == 9'(BOOT_CNT - 1)) bst_d = IMAC_DONE;
         IMAC_DONE: bst_d = IMAC_DONE;
         default:   bst_d = IMAC_IDLE;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         bst_q        <= IMAC_IDLE;
         bcnt_q       <= 9'h000;
         strap_done_q <= 1'b0;
         boot_q       <= 2'h0;
      end
      else
      begin
         bst_q        <= bst_d;
         strap_done_q <= 1'b1;
         // Strap caught on the first clock after reset release
         if (!strap_done_q) boot_q <= boot_mode_i;
         if (bst_q == IMAC_LOAD && boot_dma_ack_i)
            bcnt_q <= bcnt_q + 9'h001;
      end
   end

   // Bus slave: zero wait states, always OKAY
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         hrdata_q  <= 32'h0000_0000;
      end
      else
      begin
         wr_pend_q <= bus_wr;
         if (bus_wr) wr_addr_q <= baddr;
         if (bus_rd) hrdata_q <= rd_mux;
      end
   end

   // Control registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         system_control_reg_q <= SYSTEM_CONTROL_REG_RST;
         first_mode_reg_q     <= MODE_RST;
         second_mode_reg_q    <= MODE_RST;
         interrupt_mask_reg_q <= INTERRUPT_MASK_REG_RST;
      end
      else
      begin
         if (wr_sys) system_control_reg_q <= hwdata_i;
         if (wr_m1)  first_mode_reg_q     <= hwdata_i;
         if (wr_m2)  second_mode_reg_q    <= hwdata_i;
         if (wr_msk) interrupt_mask_reg_q <= hwdata_i;
      end
   end

   // Latch and sticky: write one to clear, a new event wins
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         interrupt_latch_reg_q <= 32'h0000_0000;
         sticky_q              <= 32'h0000_0000;
      end
      else
      begin
         interrupt_latch_reg_q <= (interrupt_latch_reg_q
            & ~(wr_lat ? hwdata_i : 32'h0000_0000))
            | (32'(ill_ev) << ILL_IRQ_BIT);
         sticky_q <= (sticky_q & ~(wr_stk ? hwdata_i : 32'h0000_0000))
            | (32'(unal_ev) << STK_UNAL_BIT)
            | (32'(io_ev) << STK_IO_BIT);
      end
   end

   // Registered outputs
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         acc_width_o         <= W32;
         acc_dual_o          <= 1'b0;
         acc_bcast_o         <= 1'b0;
         acc_postmod_first_o <= 1'b0;
         acc_mem_wdata_o     <= 48'h0000_0000_0000;
         acc_reg_rdata_o     <= 40'h00_0000_0000;
         vt_base_o           <= VT_INT_BASE;
         boot_dma_req_o      <= 1'b0;
         boot_done_o         <= 1'b0;
         illegal_input_condition_irq_o <= 1'b0;
      end
      else
      begin
         acc_width_o         <= width_d;
         acc_dual_o          <= acc_valid_i & dual_d;
         acc_bcast_o         <= acc_valid_i & bcast_d;
         acc_postmod_first_o <= acc_valid_i & bcast_d;
         acc_mem_wdata_o     <= wdata_d;
         acc_reg_rdata_o     <= rdata_d;
         vt_base_o           <= vt_d;
         boot_dma_req_o      <= (bst_d == IMAC_LOAD);
         boot_done_o         <= (bst_d == IMAC_DONE);
         illegal_input_condition_irq_o <=
            |(interrupt_latch_reg_q & interrupt_mask_reg_q);
      end
   end

   assign hrdata_o    = hrdata_q;
   assign hreadyout_o = 1'b1;
   assign hresp_o     = 1'b0;

   // Checks
   a_lw_width: assert property (@(posedge clk_i) disable iff (rst_i)
      acc_valid_i && acc_normal_i && acc_lw_i |=> acc_width_o == W64)
      else $error("forced long word not 64 bits");
   a_px_width: assert property (@(posedge clk_i) disable iff (rst_i)
      acc_valid_i && acc_px_i && !acc_lw_i |=> acc_width_o == W48)
      else $error("exchange move not 48 bits");
   a_narrow_w: assert property (@(posedge clk_i) disable iff (rst_i)
      acc_valid_i && !acc_px_i && !acc_lw_i && !blk_wide
      |=> acc_width_o == W32)
      else $error("narrow block not 32 bits");
   a_wide_w: assert property (@(posedge clk_i) disable iff (rst_i)
      acc_valid_i && !acc_lw_i && blk_wide |=> acc_width_o == W48)
      else $error("wide block not 48 bits");
   a_load_fill: assert property (@(posedge clk_i) disable iff (rst_i)
      acc_width_o == W32 |-> acc_reg_rdata_o[7:0] == 8'h00)
      else $error("low load bits not cleared");
   a_vt_place: assert property (@(posedge clk_i) disable iff (rst_i)
      strap_done_q && boot_q == IMAC_BOOT_NONE
      && !vector_table_override
      ##1 $stable(boot_q) && !vector_table_override
      |=> vt_base_o == VT_ROM_BASE)
      else $error("vector table not at ROM");
   a_vt_ovr: assert property (@(posedge clk_i) disable iff (rst_i)
      vector_table_override ##1 vector_table_override
      |=> vt_base_o == VT_INT_BASE)
      else $error("override ignored");
   a_dma_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
      acc_valid_i && acc_dma_i && !unal_flag
      && !interrupt_latch_reg_q[ILL_IRQ_BIT] && !wr_lat
      |=> !interrupt_latch_reg_q[ILL_IRQ_BIT])
      else $error("DMA raised illegal condition");
   a_io_latch: assert property (@(posedge clk_i) disable iff (rst_i)
      io_ev |=> interrupt_latch_reg_q[ILL_IRQ_BIT])
      else $error("illegal IO access not latched");
   a_unal_stk: assert property (@(posedge clk_i) disable iff (rst_i)
      acc_valid_i && acc_normal_i && acc_lw_i && acc_addr_i[0]
      |=> sticky_q[STK_UNAL_BIT]
      ##1 (sticky_q[STK_UNAL_BIT] || $past(wr_stk)))
      else $error("unaligned sticky lost");
   a_bc_simd: assert property (@(posedge clk_i) disable iff (rst_i)
      acc_valid_i && bcast_d |=> acc_dual_o && acc_postmod_first_o)
      else $error("broadcast not dual");
   a_boot_len: assert property (@(posedge clk_i) disable iff (rst_i)
      bst_q == IMAC_DONE |-> bcnt_q == 9'(BOOT_CNT) || !par_boot)
      else $error("boot DMA length wrong");
   a_boot_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
      strap_done_q && boot_q == IMAC_BOOT_NONE |-> !boot_dma_req_o)
      else $error("no-boot mode requested DMA");

   // Data path
   a_store_trunc: assert property (@(posedge clk_i) disable iff (rst_i)
      acc_valid_i && acc_write_i && narrow
      |=> acc_mem_wdata_o[31:0] == $past(acc_reg_wdata_i[39:8]))
      else $error("narrow store not truncated");
   a_load_move: assert property (@(posedge clk_i) disable iff (rst_i)
      acc_valid_i && !acc_write_i && narrow
      |=> acc_reg_rdata_o[39:8] == $past(acc_mem_rdata_i[31:0]))
      else $error("narrow load not in upper bits");
   a_px_lw: assert property (@(posedge clk_i) disable iff (rst_i)
      acc_valid_i && acc_px_i && acc_normal_i && acc_lw_i
      |=> acc_width_o == W64)
      else $error("forced exchange move not 64 bits");

   // Dual and broadcast
   a_lw_single: assert property (@(posedge clk_i) disable iff (rst_i)
      acc_valid_i && forced_lw && !bcast_d
      |=> !acc_dual_o)
      else $error("long word did not override SIMD");
   a_simd_dual: assert property (@(posedge clk_i) disable iff (rst_i)
      acc_valid_i && secondary_element_enable && !forced_lw
      |=> acc_dual_o)
      else $error("SIMD access not dual");
   a_sisd_single: assert property (@(posedge clk_i) disable iff (rst_i)
      acc_valid_i && !secondary_element_enable && !bcast_d
      |=> !acc_dual_o)
      else $error("single-data access went dual");
   a_bc_ptr: assert property (@(posedge clk_i) disable iff (rst_i)
      acc_valid_i && acc_ptr_match_i && !acc_second_address_generator_i && acc_dreg_i
      && !acc_write_i && broadcast_enable_ptr_low |=> acc_bcast_o)
      else $error("broadcast load missed");
   a_bc_store: assert property (@(posedge clk_i) disable iff (rst_i)
      acc_valid_i && acc_write_i |=> !acc_bcast_o)
      else $error("broadcast on a store");
   a_bc_sysreg: assert property (@(posedge clk_i) disable iff (rst_i)
      acc_valid_i && !acc_dreg_i |=> !acc_bcast_o)
      else $error("broadcast on a system register");
   a_postmod: assert property (@(posedge clk_i) disable iff (rst_i)
      acc_bcast_o |-> acc_postmod_first_o)
      else $error("post-modify order not flagged");

   // Interrupt and sticky
   a_unal_irq: assert property (@(posedge clk_i) disable iff (rst_i)
      unal_flag |=> interrupt_latch_reg_q[ILL_IRQ_BIT])
      else $error("monitored unaligned access not latched");
   a_irq_mask: assert property (@(posedge clk_i) disable iff (rst_i)
      !interrupt_mask_reg_q[ILL_IRQ_BIT]
      |=> !illegal_input_condition_irq_o)
      else $error("masked interrupt raised");
   a_hold_stk: assert property (@(posedge clk_i) disable iff (rst_i)
      sticky_q[STK_UNAL_BIT] && !wr_stk |=> sticky_q[STK_UNAL_BIT])
      else $error("sticky bit dropped without clear");

   c_bcast: cover property (@(posedge clk_i) acc_bcast_o);
   c_unal:  cover property (@(posedge clk_i) sticky_q[STK_UNAL_BIT]);
   c_irq:   cover property (@(posedge clk_i) illegal_input_condition_irq_o);
   c_boot:  cover property (@(posedge clk_i) boot_done_o && par_boot);
   c_dual:  cover property (@(posedge clk_i) acc_dual_o && !acc_bcast_o);
endmodule : imac_ctrl

// *** imac_core_mdl.sv ***
// Core-side model answering boot DMA word requests
`timescale 1ns/1ps
module imac_core_mdl (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic [3:0]  gap_i,
   input  wire logic        req_i,
   output logic             ack_o,
   output logic      [15:0] cnt_o
);
   logic [3:0] gap_q;
   // One pulse per word, then a rest so a finished load is not overrun
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_o <= 1'b0;
         cnt_o <= 16'h0000;
         gap_q <= 4'h0;
      end
      else if (ack_o)
         ack_o <= 1'b0;
      else if (gap_q != 4'h0)
         gap_q <= gap_q - 4'h1;
      else if (req_i)
      begin
         ack_o <= 1'b1;
         cnt_o <= cnt_o + 16'h0001;
         gap_q <= gap_i;
      end
   end
endmodule : imac_core_mdl

// *** testbench.sv ***
// Self-checking bench for the memory access mode control block
`timescale 1ns/1ps
module testbench;
   import imac_pkg::*;
   localparam int BC = 4;
   typedef struct packed {
      logic [6:0]  w;
      logic        du;
      logic        bc;
      logic [47:0] mw;
      logic [39:0] rd;
   } imac_exp_s;
   logic        clk_i, rst_i, hsel_i, hwrite_i, hready_i, hreadyout_o;
   logic        hresp_o, boot_dma_req_o, boot_done_o, boot_dma_ack_i;
   logic        acc_dual_o, acc_bcast_o, acc_postmod_first_o, irq, seen_q;
   logic        simd, bcl, bch;
   logic [1:0]  htrans_i, boot_mode_i, dw;
   logic [2:0]  hsize_i;
   logic [3:0]  gap;
   logic [6:0]  acc_width_o;
   logic [9:0]  req, r;
   logic [15:0] words;
   logic [31:0] haddr_i, hwdata_i, hrdata_o, acc_addr_i, vt_base_o;
   logic [39:0] acc_reg_wdata_i, acc_reg_rdata_o;
   logic [47:0] acc_mem_rdata_i, acc_mem_wdata_o;
   int          bad_count, checked;
   imac_exp_s   exp_q[$];
   imac_exp_s   ex;

   imac_ctrl #(.BOOT_CNT(BC)) dut_u (
      .clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
      .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
      .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
      .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
      .boot_mode_i(boot_mode_i), .acc_valid_i(req[0]),
      .acc_write_i(req[1]), .acc_addr_i(acc_addr_i), .acc_normal_i(req[2]),
      .acc_lw_i(req[3]), .acc_px_i(req[4]), .acc_dreg_i(req[5]),
      .acc_second_address_generator_i(req[6]), .acc_ptr_match_i(req[7]),
      .acc_io_reg_i(req[8]), .acc_dma_i(req[9]),
      .acc_reg_wdata_i(acc_reg_wdata_i), .acc_mem_rdata_i(acc_mem_rdata_i),
      .acc_width_o(acc_width_o), .acc_dual_o(acc_dual_o),
      .acc_bcast_o(acc_bcast_o), .acc_postmod_first_o(acc_postmod_first_o),
      .acc_mem_wdata_o(acc_mem_wdata_o), .acc_reg_rdata_o(acc_reg_rdata_o),
      .vt_base_o(vt_base_o), .boot_dma_req_o(boot_dma_req_o),
      .boot_done_o(boot_done_o), .boot_dma_ack_i(boot_dma_ack_i),
      .illegal_input_condition_irq_o(irq));
   imac_core_mdl core_u (.clk_i(clk_i), .rst_i(rst_i), .gap_i(gap),
      .req_i(boot_dma_req_o), .ack_o(boot_dma_ack_i), .cnt_o(words));

   task automatic chk(input string n, input logic [47:0] s,
      input logic [47:0] x);
      checked++;
      if (s !== x)
      begin
         bad_count++;
         $display("BAD %s expected %h seen %h", n, x, s);
      end
   endtask : chk
   task automatic complete_run();
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : complete_run
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
      hsel_i <= 1'b1;
      haddr_i <= {24'h0, a};
      htrans_i <= 2'h2;
      hwrite_i <= w;
      @(posedge clk_i);
      while (hreadyout_o !== 1'b1) @(posedge clk_i);
      htrans_i <= 2'h0;
      hwdata_i <= d;
      @(posedge clk_i);
      while (hreadyout_o !== 1'b1) @(posedge clk_i);
      q = hrdata_o;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr
   task automatic rdc(input string n, input logic [7:0] a,
      input logic [31:0] x);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(n, 48'(q), 48'(x));
   endtask : rdc
   task automatic cfg(input logic [31:0] s, input logic [31:0] m);
      wr(SYSTEM_CONTROL_REG_OFS, s);
      wr(FIRST_MODE_REG_OFS, m);
      dw = {s[DW_HI_BIT], s[DW_LO_BIT]};
      {bch, bcl, simd} = m[2:0];
   endtask : cfg
   task automatic acc(input logic [9:0] v, input logic [31:0] a);
      imac_exp_s e;
      logic [39:0] wd;
      logic [47:0] md;
      wd = 40'({$urandom, $urandom});
      md = 48'({$urandom, $urandom});
      e.bc = v[5] & ~v[1] & v[7] & (v[6] ? bch : bcl);
      if (v[2] & v[3]) e.w = W64;
      else if (v[4] | ((a >= BLK1_BASE) ? dw[1] : dw[0])) e.w = W48;
      else e.w = W32;
      e.du = e.bc | (simd & ~(v[2] & v[3]));
      e.mw = (e.w == W32) ? {16'h0000, wd[39:8]} : {wd, 8'h00};
      e.rd = (e.w == W32) ? {md[31:0], 8'h00} : md[47:8];
      exp_q.push_back(e);
      req <= v;
      acc_addr_i <= a;
      acc_reg_wdata_i <= wd;
      acc_mem_rdata_i <= md;
      @(posedge clk_i);
   endtask : acc
   task automatic do_reset(input logic [1:0] m);
      rst_i <= 1'b1;
      boot_mode_i <= m;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      // Strap lands on the first edge, the base on the second
      repeat (3) @(posedge clk_i);
   endtask : do_reset

   always @(posedge clk_i)
      seen_q <= req[0] & ~rst_i;
   // Outputs land one cycle after the access, so look mid-cycle
   always @(negedge clk_i)
   begin
      if (seen_q && exp_q.size() > 0)
      begin
         ex = exp_q.pop_front();
         chk("wid", 48'(acc_width_o), 48'(ex.w));
         chk("dual", 48'(acc_dual_o), 48'(ex.du));
         chk("bc", 48'(acc_bcast_o), 48'(ex.bc));
         chk("pm", 48'(acc_postmod_first_o), 48'(ex.bc));
         chk("mem_wdata", acc_mem_wdata_o, ex.mw);
         chk("reg_rdata", 48'(acc_reg_rdata_o), 48'(ex.rd));
      end
   end
   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   initial
   begin
      repeat (20000) @(posedge clk_i);
      bad_count++;
      complete_run();
   end
   initial
   begin
      {rst_i, hsel_i, hwrite_i, htrans_i, hsize_i, req} = '0;
      {haddr_i, hwdata_i, acc_addr_i, acc_reg_wdata_i} = '0;
      {acc_mem_rdata_i, dw, simd, bcl, bch} = '0;
      hready_i = 1'b1;
      boot_mode_i = 2'h3;
      gap = 4'h1;
      bad_count = 0;
      checked = 0;
      void'($urandom(32'h74f8));
      hsize_i = 3'h2;
      for (int m = 0; m < 4; m++)
      begin
         do_reset(2'(m));
         chk("vt", 48'(vt_base_o),
             48'((m == 3) ? VT_ROM_BASE : VT_INT_BASE));
         wr(SYSTEM_CONTROL_REG_OFS, 32'h1 << VT_OVR_BIT);
         repeat (2) @(posedge clk_i);
         chk("vt_ovr", 48'(vt_base_o), 48'(VT_INT_BASE));
      end
      gap <= 4'($urandom_range(1, 3));
      do_reset(IMAC_BOOT_PAR);
      for (int i = 0; i < 300 && boot_done_o !== 1'b1; i++) @(posedge clk_i);
      repeat (4) @(posedge clk_i);
      chk("boot_words", 48'(words), 48'(BC));
      chk("boot_req", 48'(boot_dma_req_o), 48'h0);
      rdc("status", STATUS_OFS, 32'h2);
      chk("hresp", 48'(hresp_o), 48'h0);
      chk("hready", 48'(hreadyout_o), 48'h1);
      for (int i = 0; i < 6; i++)
         rdc("rst_val", 8'(4 * i), 32'h0);
      wr(8'h1c, 32'hffff_ffff);
      rdc("unmapped", 8'h1c, 32'h0);
      wr(SYSTEM_CONTROL_REG_OFS, 32'h0000_0604);
      rdc("system_control_reg", SYSTEM_CONTROL_REG_OFS, 32'h0000_0604);
      for (int g = 0; g < 8; g++)
      begin
         cfg(32'($urandom) & 32'h0000_0600, 32'(g));
         for (int i = 0; i < 20; i++)
         begin
            r = 10'($urandom) & 10'h0ff | 10'h001;
            r[2] = r[2] | ~r[4];
            acc(r, BLK1_BASE - 32'h8 + 32'($urandom_range(0, 15)));
         end
         req <= 10'h000;
      end
      wr(SECOND_MODE_REG_OFS, (32'h1 << UNAL_MON_BIT) | 32'h1);
      rdc("second_mode_reg", SECOND_MODE_REG_OFS, 32'h0020_0001);
      wr(INTERRUPT_MASK_REG_OFS, 32'h1);
      acc(10'h305, VT_INT_BASE);
      acc(10'h00d, VT_INT_BASE + 32'h2);
      req <= 10'h000;
      repeat (4) @(posedge clk_i);
      chk("irq_quiet", 48'(irq), 48'h0);
      rdc("latch_quiet", INTERRUPT_LATCH_REG_OFS, 32'h0);
      acc(10'h00d, VT_INT_BASE + 32'h3);
      req <= 10'h000;
      repeat (4) @(posedge clk_i);
      chk("irq_unal", 48'(irq), 48'h1);
      rdc("sticky_unal", STICKY_OFS, 32'h1);
      wr(INTERRUPT_MASK_REG_OFS, 32'h0);
      repeat (3) @(posedge clk_i);
      chk("irq_masked", 48'(irq), 48'h0);
      rdc("latch_held", INTERRUPT_LATCH_REG_OFS, 32'h1);
      rdc("sticky_held", STICKY_OFS, 32'h1);
      wr(INTERRUPT_LATCH_REG_OFS, 32'h1);
      wr(STICKY_OFS, 32'h3);
      rdc("latch_clr", INTERRUPT_LATCH_REG_OFS, 32'h0);
      rdc("sticky_clr", STICKY_OFS, 32'h0);
      wr(INTERRUPT_MASK_REG_OFS, 32'h1);
      acc(10'h105, VT_INT_BASE);
      req <= 10'h000;
      repeat (4) @(posedge clk_i);
      chk("irq_io", 48'(irq), 48'h1);
      rdc("latch_io", INTERRUPT_LATCH_REG_OFS, 32'h1);
      rdc("sticky_io", STICKY_OFS, 32'h2);
      repeat (4) @(posedge clk_i);
      complete_run();
   end
endmodule : testbench
